// File: fetch_trap_detect.sv
`timescale 1ns/100ps
`default_nettype none
module fetch_trap_detect #(
  parameter logic [19:0] AREA0_LO = idle_reset_pkg::TRAP_AREA0_LO,
  parameter logic [19:0] AREA0_HI = idle_reset_pkg::TRAP_AREA0_HI,
  parameter logic [19:0] AREA1_LO = idle_reset_pkg::TRAP_AREA1_LO,
  parameter logic [19:0] AREA1_HI = idle_reset_pkg::TRAP_AREA1_HI
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic fetch_valid_in,
  input wire logic [19:0] fetch_addr_in,
  input wire logic armed_in,
  output logic hit_out
);
  typedef struct packed {
    logic hit;
  } trap_state_t;
  trap_state_t state_reg;
  trap_state_t state_next;

  // data areas: ram with special function space, and data buffer space
  function automatic logic in_trap_area(input logic [19:0] a);
    in_trap_area = (a >= AREA0_LO && a <= AREA0_HI) ||
                   (a >= AREA1_LO && a <= AREA1_HI);
  endfunction : in_trap_area

  // a fetch landing in a data area while armed, not after the unlock key
  always_comb begin
    state_next.hit = fetch_valid_in && armed_in &&
                     in_trap_area(fetch_addr_in);
  end

  // hit is a one-cycle registered pulse
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hit_out = state_reg.hit;
endmodule : fetch_trap_detect
`default_nettype wire

// File: idle_and_reset_control.sv
`timescale 1ns/100ps
`default_nettype none
module idle_and_reset_control #(
  parameter int IRQ_COUNT = 32
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic [31:0] hrdata_out,
  output logic hresp_out,
  input wire logic reset_pin_n_in,
  input wire logic fetch_valid_in,
  input wire logic [19:0] fetch_addr_in,
  input wire logic watchdog_irq_in,
  input wire logic watchdog_timeout_in,
  input wire logic [IRQ_COUNT-1:0] irq_event_in,
  output logic device_reset_out,
  output logic cpu_halt_out,
  output logic watchdog_halt_out,
  output logic watchdog_enable_out,
  output logic boot_fetch_out,
  output logic [19:0] boot_vector_out,
  output logic irq_service_out,
  output logic wake_resume_out,
  output logic master_irq_enable_out,
  output logic [IRQ_COUNT-1:0] per_source_irq_enable_out,
  output logic [IRQ_COUNT-1:0] irq_pending_latch_out,
  output logic irq_nesting_flag_out,
  output logic [3:0] register_bank_select_out,
  output logic jump_status_flag_out,
  output logic trap_armed_out,
  output logic [1:0] machine_state_out
);
  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    idle_reset_pkg::mode_t mode;
    logic [1:0] hold;
    logic dev_rst;
    logic restart;
    logic boot;
    logic [19:0] vector;
    logic halt;
    logic srv;
    logic res;
    logic trap_armed;
    logic master;
    logic nest;
    logic jump;
    logic [3:0] bank;
    logic wdt_en;
    logic [IRQ_COUNT-1:0] en;
    logic [IRQ_COUNT-1:0] pend;
    logic [3:0] cause;
    logic ph_valid;
    logic ph_write;
    logic ph_map;
    logic [15:0] ph_addr;
    logic hready;
    logic [31:0] hrdata;
  } ctl_state_t;

  localparam logic [1:0] HOLD_MC = 2'(idle_reset_pkg::RESET_HOLD_MC);
  localparam ctl_state_t CTL_RESET = '{
    mode: idle_reset_pkg::MODE_RESET,
    hold: HOLD_MC,
    dev_rst: 1'h1,
    jump: 1'h1,
    wdt_en: 1'h1,
    trap_armed: 1'h1,
    hready: 1'h1,
    default: '0
  };

  ctl_state_t state_reg;
  ctl_state_t state_next;
  logic mc_tick;
  logic trap_hit;
  logic take;
  logic wr_phase;
  logic rd_phase;
  logic scr2_wr;
  logic unlock_wr;
  logic idle_req;
  logic wake;
  logic any_cause;
  logic [3:0] causes;
  logic [7:0] wbyte;

  // ****************************************************
  // sub-blocks
  // ****************************************************
  machine_cycle_gen #(
    .STATES(idle_reset_pkg::STATES_PER_MC)
  ) u_mc (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(state_reg.restart),
    .state_out(machine_state_out),
    .tick_out(mc_tick)
  );

  fetch_trap_detect u_trap (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .fetch_valid_in(fetch_valid_in &&
                    state_reg.mode == idle_reset_pkg::MODE_NORMAL),
    .fetch_addr_in(fetch_addr_in),
    .armed_in(state_reg.trap_armed),
    .hit_out(trap_hit)
  );

  // ****************************************************
  // decode of bus phases and reset causes
  // ****************************************************
  assign take = hsel_in && hready_in &&
                htrans_in == idle_reset_pkg::HTRANS_NONSEQ &&
                hsize_in == idle_reset_pkg::HSIZE_WORD;
  assign wr_phase = state_reg.ph_valid && state_reg.ph_write &&
                    state_reg.ph_map;
  assign rd_phase = state_reg.ph_valid && !state_reg.ph_write;
  assign wbyte = hwdata_in[7:0];
  assign scr2_wr = wr_phase &&
                   state_reg.ph_addr == idle_reset_pkg::ADDR_SYS_CTRL_TWO;
  assign unlock_wr = wr_phase &&
                     state_reg.ph_addr == idle_reset_pkg::ADDR_TRAP_UNLOCK;
  assign idle_req = scr2_wr && wbyte[idle_reset_pkg::SCR2_IDLE_BIT];
  assign wake = |(state_reg.pend & state_reg.en);
  // pin, trap, watchdog and clock guard all feed the same reset
  assign causes[idle_reset_pkg::CAUSE_PIN] = !reset_pin_n_in;
  assign causes[idle_reset_pkg::CAUSE_TRAP] = trap_hit;
  assign causes[idle_reset_pkg::CAUSE_WDT] = watchdog_timeout_in;
  assign causes[idle_reset_pkg::CAUSE_CLK] = scr2_wr &&
      (!wbyte[idle_reset_pkg::SCR2_KEEP_BIT] ||
       wbyte[idle_reset_pkg::SCR2_ZERO_BIT]);
  assign any_cause = |causes;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    state_next = state_reg;
    state_next.boot = 1'h0;
    state_next.srv = 1'h0;
    state_next.res = 1'h0;
    state_next.restart = 1'h0;
    // bus: one wait cycle, then the answer
    if (state_reg.ph_valid) begin
      state_next.ph_valid = 1'h0;
      state_next.hready = 1'h1;
      state_next.hrdata = '0;
      if (rd_phase && state_reg.ph_map) begin
        case (state_reg.ph_addr)
          idle_reset_pkg::ADDR_SYS_CTRL_TWO: begin
            state_next.hrdata[7:0] = idle_reset_pkg::SCR2_READ_FIXED;
            state_next.hrdata[idle_reset_pkg::SCR2_IDLE_BIT] =
                state_reg.mode == idle_reset_pkg::MODE_IDLE;
          end
          idle_reset_pkg::ADDR_CORE_FLAGS: begin
            state_next.hrdata[idle_reset_pkg::CF_MASTER] = state_reg.master;
            state_next.hrdata[idle_reset_pkg::CF_NEST] = state_reg.nest;
            state_next.hrdata[idle_reset_pkg::CF_JUMP] = state_reg.jump;
            state_next.hrdata[idle_reset_pkg::CF_BANK_LSB +:
                              idle_reset_pkg::BANK_W] = state_reg.bank;
          end
          idle_reset_pkg::ADDR_IRQ_ENABLE: begin
            state_next.hrdata[IRQ_COUNT-1:0] = state_reg.en;
          end
          idle_reset_pkg::ADDR_IRQ_PENDING: begin
            state_next.hrdata[IRQ_COUNT-1:0] = state_reg.pend;
          end
          idle_reset_pkg::ADDR_STATUS: begin
            state_next.hrdata[idle_reset_pkg::ST_MODE_LSB +: 3] =
                state_reg.mode;
            state_next.hrdata[idle_reset_pkg::ST_CAUSE_LSB +: 4] =
                state_reg.cause;
            state_next.hrdata[idle_reset_pkg::ST_TRAP_ARMED] =
                state_reg.trap_armed;
            state_next.hrdata[idle_reset_pkg::ST_WDT_EN] = state_reg.wdt_en;
          end
          default: begin
            state_next.hrdata = '0; // unlock code is write-only
          end
        endcase
      end
    end else if (take) begin
      state_next.ph_valid = 1'h1;
      state_next.ph_write = hwrite_in;
      state_next.ph_map = haddr_in[31:16] == 16'h0000;
      state_next.ph_addr = haddr_in[15:0];
      state_next.hready = 1'h0;
    end
    // software registers, live outside reset
    if (state_reg.mode != idle_reset_pkg::MODE_RESET) begin
      if (wr_phase &&
          state_reg.ph_addr == idle_reset_pkg::ADDR_CORE_FLAGS) begin
        state_next.master = hwdata_in[idle_reset_pkg::CF_MASTER];
        state_next.nest = hwdata_in[idle_reset_pkg::CF_NEST];
        state_next.jump = hwdata_in[idle_reset_pkg::CF_JUMP];
        state_next.bank = hwdata_in[idle_reset_pkg::CF_BANK_LSB +:
                                    idle_reset_pkg::BANK_W];
      end
      if (wr_phase &&
          state_reg.ph_addr == idle_reset_pkg::ADDR_IRQ_ENABLE) begin
        state_next.en = hwdata_in[IRQ_COUNT-1:0];
      end
      // load clears a latch, but a new event in the same cycle wins
      if (wr_phase &&
          state_reg.ph_addr == idle_reset_pkg::ADDR_IRQ_PENDING) begin
        state_next.pend = hwdata_in[IRQ_COUNT-1:0] | irq_event_in;
      end else begin
        state_next.pend = state_reg.pend | irq_event_in;
      end
      if (unlock_wr && wbyte == idle_reset_pkg::TRAP_UNLOCK_KEY) begin
        state_next.trap_armed = 1'h0;
      end
    end
    // operating mode sequence
    case (state_reg.mode)
      idle_reset_pkg::MODE_RESET: begin
        if (state_reg.hold != 2'h0 && mc_tick) begin
          state_next.hold = state_reg.hold - 2'h1;
        end
        if (state_reg.hold == 2'h0 && reset_pin_n_in) begin
          state_next.mode = idle_reset_pkg::MODE_NORMAL;
          state_next.dev_rst = 1'h0;
          state_next.boot = 1'h1;
          state_next.vector = idle_reset_pkg::RESET_VECTOR;
        end
      end
      idle_reset_pkg::MODE_NORMAL: begin
        if (idle_req && !watchdog_irq_in) begin
          state_next.mode = idle_reset_pkg::MODE_IDLE;
          state_next.halt = 1'h1;
        end
      end
      idle_reset_pkg::MODE_IDLE: begin
        // halt keeps core state and program counter frozen
        if (wake) begin
          state_next.mode = idle_reset_pkg::MODE_NORMAL;
          state_next.halt = 1'h0;
          state_next.srv = state_reg.master;
          state_next.res = !state_reg.master;
        end
      end
      default: begin
        state_next.mode = idle_reset_pkg::MODE_RESET;
        state_next.dev_rst = 1'h1;
      end
    endcase
    // any cause forces reset and the documented initial values
    if (any_cause) begin
      state_next.mode = idle_reset_pkg::MODE_RESET;
      state_next.dev_rst = 1'h1;
      state_next.hold = HOLD_MC;
      state_next.restart = state_reg.mode != idle_reset_pkg::MODE_RESET;
      state_next.halt = 1'h0;
      state_next.srv = 1'h0;
      state_next.res = 1'h0;
      state_next.boot = 1'h0;
      state_next.master = 1'h0;
      state_next.en = '0;
      state_next.pend = '0;
      state_next.nest = 1'h0;
      state_next.bank = '0;
      state_next.jump = 1'h1;
      state_next.wdt_en = 1'h1;
      state_next.trap_armed = 1'h1;
      state_next.cause = state_reg.cause | causes;
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= CTL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign hreadyout_out = state_reg.hready;
  assign hrdata_out = state_reg.hrdata;
  assign hresp_out = 1'h0;
  assign device_reset_out = state_reg.dev_rst;
  assign cpu_halt_out = state_reg.halt;
  assign watchdog_halt_out = state_reg.halt;
  assign watchdog_enable_out = state_reg.wdt_en;
  assign boot_fetch_out = state_reg.boot;
  assign boot_vector_out = state_reg.vector;
  assign irq_service_out = state_reg.srv;
  assign wake_resume_out = state_reg.res;
  assign master_irq_enable_out = state_reg.master;
  assign per_source_irq_enable_out = state_reg.en;
  assign irq_pending_latch_out = state_reg.pend;
  assign irq_nesting_flag_out = state_reg.nest;
  assign register_bank_select_out = state_reg.bank;
  assign jump_status_flag_out = state_reg.jump;
  assign trap_armed_out = state_reg.trap_armed;

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_idle_entry_halts: assert property (
    state_reg.mode == idle_reset_pkg::MODE_NORMAL && idle_req &&
    !watchdog_irq_in && !any_cause |=> cpu_halt_out && watchdog_halt_out)
    else $error("idle request did not halt core");
  a_bit7_clear_resets: assert property (
    scr2_wr && !wbyte[idle_reset_pkg::SCR2_KEEP_BIT] |=>
    device_reset_out && state_reg.cause[idle_reset_pkg::CAUSE_CLK])
    else $error("clearing keep bit did not reset");
  a_scr2_read_value: assert property (
    rd_phase && state_reg.ph_map &&
    state_reg.ph_addr == idle_reset_pkg::ADDR_SYS_CTRL_TWO |=>
    hreadyout_out && hrdata_out[3:0] == 4'h0 && hrdata_out[7:5] == 3'h4)
    else $error("control register read value wrong");
  a_halt_stays: assert property (
    cpu_halt_out && !wake && !any_cause |=> cpu_halt_out)
    else $error("halt dropped without wake");
  a_wake_resumes: assert property (
    state_reg.mode == idle_reset_pkg::MODE_IDLE && wake &&
    !state_reg.master && !any_cause |=>
    wake_resume_out && !irq_service_out && !cpu_halt_out)
    else $error("wake without master enable did not resume");
  a_wake_services: assert property (
    state_reg.mode == idle_reset_pkg::MODE_IDLE && wake &&
    state_reg.master && !any_cause |=> irq_service_out && !wake_resume_out)
    else $error("wake with master enable did not service");
  a_latch_alone_sleeps: assert property (
    state_reg.mode == idle_reset_pkg::MODE_IDLE && !wake && !any_cause
    |=> cpu_halt_out && !irq_service_out && !wake_resume_out)
    else $error("woke without enabled pending source");
  a_pin_resets_now: assert property (
    !reset_pin_n_in |=> device_reset_out && !cpu_halt_out)
    else $error("reset pin did not reset at once");
  a_wdt_blocks_idle: assert property (
    idle_req && watchdog_irq_in |=> !cpu_halt_out)
    else $error("idle entered despite watchdog interrupt");
  a_reset_values: assert property (
    $rose(device_reset_out) |-> !master_irq_enable_out &&
    per_source_irq_enable_out == '0 && irq_pending_latch_out == '0 &&
    jump_status_flag_out && watchdog_enable_out && trap_armed_out)
    else $error("reset values wrong");
  a_boot_vector: assert property (
    boot_fetch_out |-> $past(device_reset_out) && !device_reset_out &&
    boot_vector_out == idle_reset_pkg::RESET_VECTOR)
    else $error("boot not from reset vector");
  a_trap_resets: assert property (
    trap_hit |=> device_reset_out &&
    state_reg.cause[idle_reset_pkg::CAUSE_TRAP])
    else $error("trap fetch did not reset");
  a_unlock_disarms: assert property (
    unlock_wr && wbyte == idle_reset_pkg::TRAP_UNLOCK_KEY &&
    state_reg.mode != idle_reset_pkg::MODE_RESET && !any_cause
    |=> !trap_armed_out ##1 !trap_armed_out || device_reset_out)
    else $error("unlock key did not disarm trap");

  c_idle_entered: cover property (!cpu_halt_out ##1 cpu_halt_out);
  c_wake_resume: cover property (wake_resume_out);
  c_wake_service: cover property (irq_service_out);
  c_trap_reset: cover property (trap_hit ##1 device_reset_out);
endmodule : idle_and_reset_control
`default_nettype wire

// File: idle_and_reset_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module idle_and_reset_control_test;
  // ****************************************************
  // bench signals and the block under test
  // ****************************************************
  localparam logic [15:0] SC = idle_reset_pkg::ADDR_SYS_CTRL_TWO;
  localparam logic [15:0] TK = idle_reset_pkg::ADDR_TRAP_UNLOCK;
  localparam logic [15:0] CF = idle_reset_pkg::ADDR_CORE_FLAGS;
  localparam logic [15:0] EN = idle_reset_pkg::ADDR_IRQ_ENABLE;
  localparam logic [15:0] PN = idle_reset_pkg::ADDR_IRQ_PENDING;
  localparam logic [15:0] ST = idle_reset_pkg::ADDR_STATUS;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, pin_n = 1'b1, fv = 1'b0;
  logic wd_irq = 1'b0, wd_to = 1'b0, hro, halt, whalt, rst_o, boot;
  logic srv, res, mst, nst, jmp, tarm, wden;
  logic [1:0] htrans = 2'h0;
  logic [1:0] ms, ms0;
  logic hrsp;
  logic [3:0] bnk;
  logic [19:0] faddr = 20'h0, vec;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, ev = 32'h0;
  logic [31:0] hrdata, en, pnd, rd;
  int err_total = 0, tests_run = 0, n_boot = 0, n_res = 0, n_srv = 0;

  // free-running 100 MHz clock
  always #5 clk_in = ~clk_in;

  idle_and_reset_control dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(idle_reset_pkg::HSIZE_WORD),
    .hwdata_in(hwdata), .hready_in(hro), .hreadyout_out(hro),
    .hrdata_out(hrdata), .hresp_out(hrsp), .reset_pin_n_in(pin_n),
    .fetch_valid_in(fv), .fetch_addr_in(faddr), .watchdog_irq_in(wd_irq),
    .watchdog_timeout_in(wd_to), .irq_event_in(ev), .device_reset_out(rst_o),
    .cpu_halt_out(halt), .watchdog_halt_out(whalt),
    .watchdog_enable_out(wden), .boot_fetch_out(boot),
    .boot_vector_out(vec), .irq_service_out(srv), .wake_resume_out(res),
    .master_irq_enable_out(mst), .per_source_irq_enable_out(en),
    .irq_pending_latch_out(pnd), .irq_nesting_flag_out(nst),
    .register_bank_select_out(bnk), .jump_status_flag_out(jmp),
    .trap_armed_out(tarm), .machine_state_out(ms));

  // count the one-cycle pulses of the block
  always @(posedge clk_in) begin
    n_boot += (boot === 1'b1);
    n_res += (res === 1'b1);
    n_srv += (srv === 1'b1);
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk

  task report_and_stop();
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  // one ahb-lite single word transfer, waits on hready each phase
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= idle_reset_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {16'h0, a};
    do @(posedge clk_in); while (hro !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hro !== 1'b1);
    rd = hrdata;
  endtask : bus

  task wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rdc(input string n, input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask : rdc

  // waits for the next reset exit, seen as a boot fetch pulse
  task rst_wait();
    int b;
    b = n_boot;
    for (int i = 0; i < 80 && n_boot == b; i++) @(posedge clk_in);
    chk("reset exit", n_boot, b + 1);
  endtask : rst_wait

  task irq(input int b);
    @(posedge clk_in);
    ev <= 32'h1 << b;
    @(posedge clk_in);
    ev <= 32'h0;
    cyc(4);
  endtask : irq

  task fetch(input logic [19:0] a);
    @(posedge clk_in);
    fv <= 1'b1;
    faddr <= a;
    @(posedge clk_in);
    fv <= 1'b0;
    cyc(4);
  endtask : fetch

  // hang guard
  initial begin
    cyc(5000);
    err_total++;
    report_and_stop();
  end

  // main sequence
  initial begin
    cyc(2);
    rst_n_in <= 1'b1;
    rst_wait();
    chk("vector", {12'h0, vec}, 32'hffffc);
    chk("flags", {bnk, jmp, mst, nst, wden, tarm}, 32'h13);
    chk("en pend", en | pnd, 32'h0);
    // one state per clock, four states to a machine cycle
    ms0 = ms;
    cyc(1);
    chk("mc step", ms, 2'(ms0 + 2'h1));
    cyc(3);
    chk("mc wrap", ms, ms0);
    rdc("status", ST, 32'h302);
    rdc("scr2", SC, 32'h80);
    rdc("unmapped", 16'h0040, 32'h0);
    chk("okay", hrsp, 1'b0);
    wr(EN, 32'h1);
    wr(SC, 32'h90);
    cyc(1);
    chk("halt", {halt, whalt}, 32'h3);
    rdc("idle", ST, 32'h304);
    irq(1);
    chk("latch only", halt, 1'b1);
    irq(0);
    chk("resume", n_res, 1);
    chk("halt off", {halt, n_srv[0]}, 32'h0);
    chk("latch kept", pnd, 32'h3);
    wr(CF, 32'h5);
    wr(PN, 32'h0);
    wr(SC, 32'h90);
    irq(0);
    chk("service", {halt, n_srv[1:0]}, 32'h1);
    wr(PN, 32'h0);
    wd_irq <= 1'b1;
    wr(SC, 32'h90);
    cyc(2);
    chk("no idle", halt, 1'b0);
    wd_irq <= 1'b0;
    wr(SC, 32'h90);
    cyc(1);
    chk("idle again", halt, 1'b1);
    pin_n <= 1'b0;
    cyc(2);
    chk("pin", rst_o, 1'b1);
    cyc(12);
    pin_n <= 1'b1;
    rst_wait();
    chk("after pin", {halt, mst, en[0], jmp}, 32'h1);
    rdc("pin cause", ST, 32'h312);
    wr(SC, 32'h00);
    rst_wait();
    wr(SC, 32'ha0);
    rst_wait();
    rdc("clk cause", ST, 32'h392);
    @(posedge clk_in);
    wd_to <= 1'b1;
    @(posedge clk_in);
    wd_to <= 1'b0;
    rst_wait();
    fetch(20'h002c0);
    chk("outside", rst_o, 1'b0);
    fetch(20'h002bf);
    rst_wait();
    rdc("causes", ST, 32'h3f2);
    fetch(20'h01f00);
    rst_wait();
    wr(TK, 32'h55);
    chk("armed", tarm, 1'b1);
    rdc("key read", TK, 32'h0);
    wr(TK, 32'hd2);
    chk("disarmed", tarm, 1'b0);
    fetch(20'h00100);
    chk("no trap", rst_o, 1'b0);
    report_and_stop();
  end
endmodule : idle_and_reset_control_test
`default_nettype wire

// File: idle_reset_pkg.sv
`default_nettype none
package idle_reset_pkg;
  // ****************************************************
  // register map and field layout
  // ****************************************************
  localparam logic [15:0] IDX_SYS_CTRL_TWO = 16'h0039;
  localparam logic [15:0] IDX_TRAP_UNLOCK = 16'h1f95;
  localparam logic [15:0] ADDR_SYS_CTRL_TWO = {IDX_SYS_CTRL_TWO[13:0], 2'h0};
  localparam logic [15:0] ADDR_TRAP_UNLOCK = {IDX_TRAP_UNLOCK[13:0], 2'h0};
  localparam logic [15:0] ADDR_CORE_FLAGS = 16'h0000;
  localparam logic [15:0] ADDR_IRQ_ENABLE = 16'h0004;
  localparam logic [15:0] ADDR_IRQ_PENDING = 16'h0008;
  localparam logic [15:0] ADDR_STATUS = 16'h000c;
  localparam int SCR2_KEEP_BIT = 7;
  localparam int SCR2_ZERO_BIT = 5;
  localparam int SCR2_IDLE_BIT = 4;
  localparam logic [7:0] SCR2_READ_FIXED = 8'h80;
  localparam logic [7:0] TRAP_UNLOCK_KEY = 8'hd2;
  localparam int CF_MASTER = 0;
  localparam int CF_NEST = 1;
  localparam int CF_JUMP = 2;
  localparam int CF_BANK_LSB = 4;
  localparam int BANK_W = 4;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_CAUSE_LSB = 4;
  localparam int ST_TRAP_ARMED = 8;
  localparam int ST_WDT_EN = 9;
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_TRAP = 1;
  localparam int CAUSE_WDT = 2;
  localparam int CAUSE_CLK = 3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ****************************************************
  // addresses, reset values and timing
  // ****************************************************
  localparam logic [19:0] RESET_VECTOR = 20'hffffc;
  localparam logic [19:0] TRAP_AREA0_LO = 20'h00000;
  localparam logic [19:0] TRAP_AREA0_HI = 20'h002bf;
  localparam logic [19:0] TRAP_AREA1_LO = 20'h01f00;
  localparam logic [19:0] TRAP_AREA1_HI = 20'h01fff;
  localparam int CLK_MHZ = 100;
  localparam int STATES_PER_MC = 4;
  localparam int RESET_MIN_NS = 120;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_HOLD_MC = RESET_MIN_CYCLES / STATES_PER_MC;
  typedef enum logic [2:0] {
    MODE_RESET = 3'h1,
    MODE_NORMAL = 3'h2,
    MODE_IDLE = 3'h4
  } mode_t;
endpackage : idle_reset_pkg
`default_nettype wire

// File: machine_cycle_gen.sv
`timescale 1ns/100ps
`default_nettype none
module machine_cycle_gen #(
  parameter int STATES = idle_reset_pkg::STATES_PER_MC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  output logic [$clog2(STATES)-1:0] state_out,
  output logic tick_out
);
  localparam int W = $clog2(STATES);
  localparam logic [W-1:0] LAST = W'(STATES - 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } mc_state_t;
  mc_state_t state_reg;
  mc_state_t state_next;

  // one state per clock, tick on the last state of a machine cycle
  always_comb begin
    state_next = state_reg;
    if (clear_in || state_reg.cnt == LAST) begin
      state_next.cnt = '0;
    end else begin
      state_next.cnt = state_reg.cnt + W'(1);
    end
    state_next.tick = !clear_in && (state_next.cnt == LAST);
  end

  // state register, prescaler cleared by reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state_out = state_reg.cnt;
  assign tick_out = state_reg.tick;
endmodule : machine_cycle_gen
`default_nettype wire
